/* design/pulse_interval_capture_channel.sv */
// Operation
// RQ1: a valid edge on the capture input pin captures the running count
// RQ2: start trigger while enabled also acts as a capture trigger
// RQ3: software computes interval as clock period times (0x10000*overflow + value + 1)
// RQ4: capture input is sampled on the selected operating clock
// RQ5: counter counts up from 0x0000 after start, one step per count clock
// RQ6: capture copies count to data register, clears counter, pulses interrupt
// RQ7: overflow flag updated at every capture to describe the captured value
// RQ8: several overflows in one period still read only as overflow set
// RQ9: software selects pin edges as start and capture trigger with code 001b
// RQ10: selected timer input or software trigger may serve as start and capture
// RQ11: start interrupt enable raises interrupt and inverts output at count start
// RQ12: mode field 010b selects capture; bits 5:4 and 13 stay zero
// RQ13: edge select chooses falling, rising or both; code 11 is prohibited
// RQ14: software keeps mode bit 11 at zero for this mode
// RQ15: count clock source 0 advances counter on operating clock
// RQ16: operating clock select picks first, second, third or fourth prescaled clock
// RQ17: software keeps output enable and level at zero; output pin not driven
// RQ18: software keeps output style and polarity at zero
// RQ19: start trigger sets enabled flag, clears counter and self-clears
// RQ20: while running software changes only the edge select field
// RQ21: stop trigger clears enabled flag, counter holds, trigger self-clears
// RQ22: counter wraps at full count and remembers overflow until next capture
`timescale 1ns/1ns
`default_nettype none
module pulse_interval_capture_channel #(
  parameter int  CHANNEL    = 1,
  parameter int  NUM_CLOCKS = 4,
  parameter bit  WIDE_CKS   = 1'b1
) (
  // clock and reset
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_resetn,
  // register port
  input  wire logic [3:0]            i_addr,
  input  wire logic [15:0]           i_wdata,
  input  wire logic                  i_write,
  input  wire logic                  i_read,
  output logic      [15:0]           o_rdata,
  // prescaled clock enables
  input  wire logic [NUM_CLOCKS-1:0] i_prescaled_ticks,
  // trigger sources
  input  wire logic                  i_capture_input_pin,
  input  wire logic                  i_timer_input_a,
  input  wire logic                  i_timer_input_b,
  // channel outputs
  output logic                       o_channel_interrupt,
  output logic                       o_timer_output_pin,
  output logic                       o_channel_enabled_flag
);
  // output registers are eight bits wide, one bit per channel
  if (CHANNEL < 0 || CHANNEL > 7) begin : g_bad_channel
    $error("channel number out of range");
  end
  if (NUM_CLOCKS != 4) begin : g_bad_clocks
    $error("four prescaled clocks required");
  end
  // third and fourth clocks exist only on the wide channels [RQ16]
  if (WIDE_CKS && CHANNEL != 1 && CHANNEL != 3) begin : g_bad_wide
    $error("third and fourth clocks only on channels 1 and 3");
  end

  capture_pkg::reg_req_s req;
  capture_pkg::capture_s cap;

  logic [15:0] channel_mode_config;
  logic [7:0]  timer_output_level;
  logic [7:0]  timer_output_enable;
  logic [7:0]  timer_output_polarity;
  logic [7:0]  timer_output_style;
  logic [1:0]  input_select;
  logic [15:0] channel_counter;
  logic [15:0] capture_data_reg;
  logic        overflow_flag;
  logic        overflow_seen;
  logic        op_tick;
  logic        pin_edge;
  logic        start_trig;
  logic        stop_trig;
  logic        sel_a_prev;
  logic        sel_b_prev;
  logic        ext_trig;
  logic        trigger;
  logic        count_tick;
  logic        capture_mode;
  logic        next_counter_wrap;

  assign req = '{write: i_write, read: i_read, addr: i_addr, wdata: i_wdata};

  function automatic logic wr_at(input capture_pkg::reg_req_s r, input logic [3:0] a);
    return r.write && (r.addr == a);
  endfunction : wr_at

  // operating clock selection [RQ16]
  clock_tick_select #(
    .NUM_CLOCKS (NUM_CLOCKS)
  ) u_tick (
    .i_clk_sys (i_clk_sys),
    .i_resetn  (i_resetn),
    .i_ticks   (i_prescaled_ticks),
    .i_sel     (channel_mode_config[capture_pkg::POS_CKS +: 2]),
    .i_wide_ok (WIDE_CKS),
    .o_tick    (op_tick)
  );

  // pin sampled on operating clock, edge chosen by field [RQ4] [RQ13]
  edge_sampler u_edge (
    .i_clk_sys  (i_clk_sys),
    .i_resetn   (i_resetn),
    .i_tick     (op_tick),
    .i_level    (i_capture_input_pin),
    .i_edge_sel (channel_mode_config[capture_pkg::POS_EDGE +: 2]),
    .o_edge     (pin_edge)
  );

  assign capture_mode = channel_mode_config[capture_pkg::POS_MODE +: 3] == capture_pkg::MODE_CAPTURE; // [RQ12]
  // count source 0 selects operating clock; other source not supported here [RQ15]
  assign count_tick   = op_tick & ~channel_mode_config[capture_pkg::BIT_CCS];
  assign start_trig   = wr_at(req, capture_pkg::ADDR_START) & i_wdata[0];
  assign stop_trig    = wr_at(req, capture_pkg::ADDR_STOP) & i_wdata[0];

  // alternative trigger sources: selected timer input rising edges [RQ10]
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      sel_a_prev <= 1'b0;
      sel_b_prev <= 1'b0;
    end else begin
      sel_a_prev <= i_timer_input_a;
      sel_b_prev <= i_timer_input_b;
    end
  end

  always_comb begin
    unique case (capture_pkg::trig_src_e'(input_select))
      capture_pkg::TRIG_SRC_PIN:
        ext_trig = pin_edge & (channel_mode_config[capture_pkg::POS_TRIG +: 3] == capture_pkg::TRIG_PIN); // [RQ1]
      capture_pkg::TRIG_SRC_SELA: ext_trig = i_timer_input_a & ~sel_a_prev; // [RQ10]
      capture_pkg::TRIG_SRC_SELB: ext_trig = i_timer_input_b & ~sel_b_prev; // [RQ10]
      capture_pkg::TRIG_SRC_SW:   ext_trig = 1'b0;
    endcase
  end

  // capture triggers: valid edge or start trigger while enabled [RQ1] [RQ2]
  assign trigger = capture_mode & o_channel_enabled_flag & (ext_trig | start_trig);

  // enabled flag: start sets, stop clears; trigger bits are never stored [RQ19] [RQ21]
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn)       o_channel_enabled_flag <= 1'b0;
    else if (start_trig) o_channel_enabled_flag <= 1'b1;
    else if (stop_trig)  o_channel_enabled_flag <= 1'b0;
  end

  assign next_counter_wrap = count_tick && (channel_counter == 16'hFFFF);

  // up counter from zero; clears on start and capture; holds when stopped [RQ5] [RQ6] [RQ21] [RQ22]
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn)                                  channel_counter <= capture_pkg::RESET_COUNT;
    else if (start_trig && !o_channel_enabled_flag) channel_counter <= capture_pkg::RESET_COUNT; // [RQ19]
    else if (trigger)                               channel_counter <= capture_pkg::RESET_COUNT; // [RQ6]
    else if (o_channel_enabled_flag && capture_mode && count_tick)
      channel_counter <= channel_counter + 16'h0001; // [RQ5] [RQ22]
  end

  // overflow remembered until capture; several wraps still just one flag [RQ8] [RQ22]
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn)                                  overflow_seen <= 1'b0;
    else if (trigger || (start_trig && !o_channel_enabled_flag)) overflow_seen <= 1'b0;
    else if (o_channel_enabled_flag && capture_mode && next_counter_wrap) overflow_seen <= 1'b1;
  end

  // capture copies count and refreshes the overflow flag [RQ6] [RQ7]
  always_comb begin
    cap.valid    = trigger;
    cap.value    = channel_counter;
    cap.overflow = overflow_seen | (o_channel_enabled_flag & next_counter_wrap);
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      capture_data_reg <= capture_pkg::RESET_DATA;
      overflow_flag    <= 1'b0;
    end else if (cap.valid) begin
      capture_data_reg <= cap.value; // [RQ6]
      overflow_flag    <= cap.overflow; // [RQ7] [RQ8]
    end
  end

  // interrupt on capture or on count start when start irq enabled [RQ6] [RQ11]
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) o_channel_interrupt <= 1'b0;
    else           o_channel_interrupt <= trigger |
                     (start_trig & ~o_channel_enabled_flag & channel_mode_config[capture_pkg::BIT_IRQ_EN]);
  end

  // timer output: inverts at count start with irq enable, only when output enabled [RQ11] [RQ17]
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) o_timer_output_pin <= 1'b0;
    else if (!timer_output_enable[CHANNEL]) o_timer_output_pin <= timer_output_level[CHANNEL];
    else if (start_trig && !o_channel_enabled_flag && channel_mode_config[capture_pkg::BIT_IRQ_EN])
      o_timer_output_pin <= ~o_timer_output_pin;
  end

  // mode register: fixed-zero bits masked; only edge field changes while running [RQ12] [RQ20]
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) channel_mode_config <= capture_pkg::RESET_MODE;
    else if (wr_at(req, capture_pkg::ADDR_MODE)) begin
      if (o_channel_enabled_flag)
        channel_mode_config[capture_pkg::POS_EDGE +: 2] <= i_wdata[capture_pkg::POS_EDGE +: 2]; // [RQ13]
      else
        channel_mode_config <= i_wdata & capture_pkg::MODE_WRITE_MASK; // [RQ12]
    end
  end

  // output control registers, frozen while running; channel 0 style and polarity fixed
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      timer_output_level    <= 8'h00;
      timer_output_enable   <= 8'h00;
      timer_output_polarity <= 8'h00;
      timer_output_style    <= 8'h00;
      input_select          <= 2'h0;
    end else if (!o_channel_enabled_flag) begin
      if (wr_at(req, capture_pkg::ADDR_OUTLVL)) timer_output_level  <= i_wdata[7:0];
      if (wr_at(req, capture_pkg::ADDR_OUTEN))  timer_output_enable <= i_wdata[7:0];
      if (wr_at(req, capture_pkg::ADDR_OUTPOL)) timer_output_polarity <= i_wdata[7:0] & 8'hFE; // [RQ18]
      if (wr_at(req, capture_pkg::ADDR_OUTSTY)) timer_output_style    <= i_wdata[7:0] & 8'hFE; // [RQ18]
      if (wr_at(req, capture_pkg::ADDR_INSEL))  input_select <= i_wdata[1:0]; // [RQ10]
    end
  end

  // read data one cycle after the read strobe; unmapped reads zero
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) o_rdata <= 16'h0000;
    else if (req.read) begin
      unique case (req.addr)
        capture_pkg::ADDR_MODE:    o_rdata <= channel_mode_config;
        capture_pkg::ADDR_STATUS:  o_rdata <= {15'h0000, overflow_flag}; // [RQ3]
        capture_pkg::ADDR_DATA:    o_rdata <= capture_data_reg; // [RQ3]
        capture_pkg::ADDR_COUNT:   o_rdata <= channel_counter;
        capture_pkg::ADDR_OUTLVL:  o_rdata <= {8'h00, timer_output_level};
        capture_pkg::ADDR_OUTEN:   o_rdata <= {8'h00, timer_output_enable};
        capture_pkg::ADDR_OUTPOL:  o_rdata <= {8'h00, timer_output_polarity};
        capture_pkg::ADDR_OUTSTY:  o_rdata <= {8'h00, timer_output_style};
        capture_pkg::ADDR_INSEL:   o_rdata <= {14'h0000, input_select};
        capture_pkg::ADDR_ENABLED: o_rdata <= {15'h0000, o_channel_enabled_flag};
        default:                   o_rdata <= 16'h0000;
      endcase
    end else o_rdata <= 16'h0000;
  end
endmodule : pulse_interval_capture_channel
`default_nettype wire

/* design/capture_pkg.sv */
package capture_pkg;

  // register indices on the plain register port
  localparam logic [3:0] ADDR_MODE    = 4'h0;
  localparam logic [3:0] ADDR_START   = 4'h1;
  localparam logic [3:0] ADDR_STOP    = 4'h2;
  localparam logic [3:0] ADDR_STATUS  = 4'h3;
  localparam logic [3:0] ADDR_DATA    = 4'h4;
  localparam logic [3:0] ADDR_COUNT   = 4'h5;
  localparam logic [3:0] ADDR_OUTLVL  = 4'h6;
  localparam logic [3:0] ADDR_OUTEN   = 4'h7;
  localparam logic [3:0] ADDR_OUTPOL  = 4'h8;
  localparam logic [3:0] ADDR_OUTSTY  = 4'h9;
  localparam logic [3:0] ADDR_INSEL   = 4'hA;
  localparam logic [3:0] ADDR_ENABLED = 4'hB;

  // mode register field positions
  localparam int BIT_IRQ_EN    = 0;
  localparam int POS_MODE      = 1;
  localparam int POS_EDGE      = 6;
  localparam int POS_TRIG      = 8;
  localparam int BIT_SPLIT     = 11;
  localparam int BIT_CCS       = 12;
  localparam int POS_CKS       = 14;
  localparam logic [15:0] MODE_WRITE_MASK = 16'hDFCF;

  localparam logic [15:0] RESET_MODE  = 16'h0000;
  localparam logic [15:0] RESET_COUNT = 16'h0000;
  localparam logic [15:0] RESET_DATA  = 16'h0000;
  localparam logic [16:0] OVF_SPAN    = 17'h10000;

  localparam logic [2:0] MODE_CAPTURE = 3'h2;
  localparam logic [2:0] TRIG_PIN     = 3'h1;

  typedef enum logic [1:0] {
    EDGE_FALL = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_BOTH = 2'h2,
    EDGE_BAD  = 2'h3
  } edge_sel_e;

  typedef enum logic [1:0] {
    TRIG_SRC_PIN  = 2'h0,
    TRIG_SRC_SELA = 2'h1,
    TRIG_SRC_SELB = 2'h2,
    TRIG_SRC_SW   = 2'h3
  } trig_src_e;

  typedef struct packed {
    logic        write;
    logic        read;
    logic [3:0]  addr;
    logic [15:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic        valid;
    logic [15:0] value;
    logic        overflow;
  } capture_s;

endpackage : capture_pkg

/* design/clock_tick_select.sv */
`timescale 1ns/1ns
`default_nettype none
module clock_tick_select #(
  parameter int NUM_CLOCKS = 4
) (
  // clock and reset
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_resetn,
  // prescaled enables and choice
  input  wire logic [NUM_CLOCKS-1:0] i_ticks,
  input  wire logic [1:0]            i_sel,
  input  wire logic                  i_wide_ok,
  // chosen operating clock tick
  output logic                       o_tick
);
  // the field decode below serves exactly four prescaled clocks
  if (NUM_CLOCKS != 4) begin : g_bad_clocks
    $error("clock_tick_select needs four prescaled clocks");
  end

  logic next_tick;

  // field order: 00 first, 10 second, 01 third, 11 fourth; third/fourth only on wide channels
  always_comb begin
    unique case (i_sel)
      2'h0: next_tick = i_ticks[0];
      2'h2: next_tick = i_ticks[1];
      2'h1: next_tick = i_wide_ok ? i_ticks[2] : i_ticks[0];
      2'h3: next_tick = i_wide_ok ? i_ticks[3] : i_ticks[1];
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) o_tick <= 1'b0;
    else           o_tick <= next_tick;
  end
endmodule : clock_tick_select
`default_nettype wire

/* design/edge_sampler.sv */
`timescale 1ns/1ns
`default_nettype none
module edge_sampler (
  // clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_resetn,
  // sampling
  input  wire logic       i_tick,
  input  wire logic       i_level,
  input  wire logic [1:0] i_edge_sel,
  // detected valid edge, one cycle
  output logic            o_edge
);
  logic sampled;
  logic prev;
  logic rise;
  logic fall;

  // input sampled only on operating clock ticks
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      sampled <= 1'b0;
      prev    <= 1'b0;
    end else if (i_tick) begin
      sampled <= i_level;
      prev    <= sampled;
    end
  end

  assign rise = i_tick & sampled & ~prev;
  assign fall = i_tick & ~sampled & prev;

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) o_edge <= 1'b0;
    else begin
      unique case (capture_pkg::edge_sel_e'(i_edge_sel))
        capture_pkg::EDGE_FALL: o_edge <= fall;
        capture_pkg::EDGE_RISE: o_edge <= rise;
        capture_pkg::EDGE_BOTH: o_edge <= rise | fall;
        capture_pkg::EDGE_BAD:  o_edge <= 1'b0;
      endcase
    end
  end
endmodule : edge_sampler
`default_nettype wire

/* verif/pulse_source.sv */
`timescale 1ns/1ns
`default_nettype none
module pulse_source (
  // clock
  input  wire logic       i_clk_sys,
  // level length in cycles
  input  wire logic [7:0] i_half,
  // pulse output
  output logic            o_pin
);
  logic [7:0] count;
  initial begin
    o_pin = 1'b0;
    count = 8'h00;
  end
  // square wave, each level held i_half cycles, changed just after an edge
  always @(posedge i_clk_sys) begin
    if (count + 8'h01 >= i_half) begin
      count <= 8'h00;
      o_pin <= ~o_pin;
    end else begin
      count <= count + 8'h01;
    end
  end
endmodule : pulse_source
`default_nettype wire

/* verif/pulse_interval_capture_channel_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module pulse_interval_capture_channel_asserts #(
  parameter int NUM_CLOCKS = 4
) (
  // clock and reset
  input wire logic                  i_clk_sys,
  input wire logic                  i_resetn,
  // register port
  input wire logic [3:0]            i_addr,
  input wire logic [15:0]           i_wdata,
  input wire logic                  i_write,
  input wire logic                  i_read,
  input wire logic [15:0]           o_rdata,
  // prescaled clock enables and trigger sources
  input wire logic [NUM_CLOCKS-1:0] i_prescaled_ticks,
  input wire logic                  i_capture_input_pin,
  input wire logic                  i_timer_input_a,
  input wire logic                  i_timer_input_b,
  // channel outputs
  input wire logic                  o_channel_interrupt,
  input wire logic                  o_timer_output_pin,
  input wire logic                  o_channel_enabled_flag
);
  logic start_wr;
  logic stop_wr;
  assign start_wr = i_write && i_addr == capture_pkg::ADDR_START && i_wdata[0];
  assign stop_wr  = i_write && i_addr == capture_pkg::ADDR_STOP && i_wdata[0];
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  property p_start_sets; start_wr |=> o_channel_enabled_flag; endproperty
  a_start_sets: assert property (p_start_sets) else $error("start write left channel idle");
  property p_stop_clears; stop_wr |=> !o_channel_enabled_flag; endproperty
  a_stop_clears: assert property (p_stop_clears) else $error("stop write left channel running");
  property p_run_holds; o_channel_enabled_flag && !stop_wr |=> o_channel_enabled_flag; endproperty
  a_run_holds: assert property (p_run_holds) else $error("channel stopped without stop write");
  property p_rdata_idle; !$past(i_read) |-> o_rdata == 16'h0000; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
  property p_flag_read;
    i_read && i_addr == capture_pkg::ADDR_ENABLED |=> o_rdata == {15'h0000, $past(o_channel_enabled_flag)};
  endproperty
  a_flag_read: assert property (p_flag_read) else $error("enabled flag read mismatch");
  // level writes reach the pin one cycle after the register, start toggles at once
  property p_out_change; $changed(o_timer_output_pin) |-> $past(i_write) || $past(i_write, 2); endproperty
  a_out_change: assert property (p_out_change) else $error("timer output moved without write");
  property p_irq_cause; o_channel_interrupt |-> $past(o_channel_enabled_flag) || $past(start_wr); endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt while idle");
  property p_irq_start; o_channel_interrupt && !$past(o_channel_enabled_flag) |-> $past(start_wr); endproperty
  a_irq_start: assert property (p_irq_start) else $error("interrupt from idle without start");
  c_start: cover property (start_wr);
  c_stop: cover property (stop_wr);
  c_capture: cover property (o_channel_interrupt && $past(o_channel_enabled_flag));
endmodule : pulse_interval_capture_channel_asserts
bind pulse_interval_capture_channel pulse_interval_capture_channel_asserts #(.NUM_CLOCKS(NUM_CLOCKS)) u_asserts (
  .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata), .i_write(i_write),
  .i_read(i_read), .o_rdata(o_rdata), .i_prescaled_ticks(i_prescaled_ticks),
  .i_capture_input_pin(i_capture_input_pin), .i_timer_input_a(i_timer_input_a),
  .i_timer_input_b(i_timer_input_b), .o_channel_interrupt(o_channel_interrupt),
  .o_timer_output_pin(o_timer_output_pin), .o_channel_enabled_flag(o_channel_enabled_flag));
`default_nettype wire

/* verif/pulse_interval_capture_channel_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module pulse_interval_capture_channel_tb_top;
  logic        clk, rstn, write, read, pin, pin_b, irq, tout, en;
  logic [3:0]  addr, ticks;
  logic [15:0] wdata, rdata, v;
  integer      seed;
  int          failures, comparisons, irq_cnt, cnt, k, saved;
  pulse_interval_capture_channel dut (
    .i_clk_sys(clk), .i_resetn(rstn), .i_addr(addr), .i_wdata(wdata), .i_write(write), .i_read(read),
    .o_rdata(rdata), .i_prescaled_ticks(ticks), .i_capture_input_pin(pin), .i_timer_input_a(pin),
    .i_timer_input_b(pin_b), .o_channel_interrupt(irq), .o_timer_output_pin(tout), .o_channel_enabled_flag(en));
  pulse_source src_a (.i_clk_sys(clk), .i_half(8'd11), .o_pin(pin));
  pulse_source src_b (.i_clk_sys(clk), .i_half(8'd7), .o_pin(pin_b));
  always #25 clk = ~clk;
  always @(negedge clk) begin
    if (irq === 1'b1) irq_cnt++;
  end
  function automatic logic [15:0] mw(input logic ie, input logic [1:0] e, input logic [2:0] sts, input logic [1:0] cks);
    return {cks, 3'h0, sts, e, 2'h0, capture_pkg::MODE_CAPTURE, ie};
  endfunction : mw
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    write <= 1'b1;
    @(posedge clk);
    write <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [3:0] a);
    addr <= a;
    read <= 1'b1;
    @(posedge clk);
    read <= 1'b0;
    #1;
    v = rdata;
    @(posedge clk);
  endtask : rd
  task automatic run(input int n, input int idx, input bit full);
    logic [3:0] t;
    repeat (n) begin
      t = full ? 4'hF : 4'($random(seed));
      ticks <= t;
      @(posedge clk);
      cnt += int'(t[idx]);
    end
    ticks <= 4'h0;
    // one more edge so the last tick has reached the counter
    @(posedge clk);
  endtask : run
  task automatic wait_irq;
    int n;
    for (n = 0; n < 500; n++) begin
      @(negedge clk);
      if (irq === 1'b1) break;
    end
    if (n == 500) failures++;
    @(posedge clk);
  endtask : wait_irq
  task automatic summarize;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (90000) @(posedge clk);
    failures++;
    summarize;
  end
  initial begin
    seed = 32'h9955e536;
    {clk, rstn, write, read, addr, wdata, ticks} = '0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(capture_pkg::ADDR_MODE); chk("mode reset", v, capture_pkg::RESET_MODE);
    wr(capture_pkg::ADDR_MODE, 16'hFFFF);
    rd(capture_pkg::ADDR_MODE); chk("mode mask", v, capture_pkg::MODE_WRITE_MASK);
    rd(4'hF); chk("unmapped", v, 16'h0000);
    wr(capture_pkg::ADDR_OUTLVL, 16'h0002);
    wr(capture_pkg::ADDR_OUTPOL, 16'hFFFF);
    rd(capture_pkg::ADDR_OUTPOL); chk("polarity", v, 16'h00FE);
    chk("output level", {15'h0, tout}, 16'h0001);
    wr(capture_pkg::ADDR_OUTPOL, 16'h0000);
    wr(capture_pkg::ADDR_OUTLVL, 16'h0000);
    wr(capture_pkg::ADDR_INSEL, 16'h0003);
    for (k = 0; k < 4; k++) begin
      wr(capture_pkg::ADDR_MODE, mw(k[0], 2'h1, 3'h0, k[1:0]));
      irq_cnt = 0;
      wr(capture_pkg::ADDR_START, 16'h0001);
      chk("enabled", {15'h0, en}, 16'h0001);
      rd(capture_pkg::ADDR_ENABLED); chk("enabled reg", v, 16'h0001);
      cnt = 0;
      run(20 + ($random(seed) & 31), k[0] * 2 + k[1], 1'b0);
      wr(capture_pkg::ADDR_START, 16'h0001);
      rd(capture_pkg::ADDR_DATA); chk("captured", v, cnt[15:0]);
      rd(capture_pkg::ADDR_STATUS); chk("status", v, 16'h0000);
      rd(capture_pkg::ADDR_COUNT); chk("cleared", v, 16'h0000);
      chk("irq count", irq_cnt[15:0], 16'(k[0] + 1));
      chk("output", {15'h0, tout}, 16'h0000);
      cnt = 0;
      run(10, k[0] * 2 + k[1], 1'b0);
      wr(capture_pkg::ADDR_STOP, 16'h0001);
      saved = cnt;
      run(8, 0, 1'b1);
      rd(capture_pkg::ADDR_COUNT); chk("held", v, saved[15:0]);
      chk("stopped", {15'h0, en}, 16'h0000);
    end
    wr(capture_pkg::ADDR_MODE, mw(1'b0, 2'h1, 3'h0, 2'h0));
    wr(capture_pkg::ADDR_START, 16'h0001);
    run(65543, 0, 1'b1);
    wr(capture_pkg::ADDR_START, 16'h0001);
    rd(capture_pkg::ADDR_DATA); chk("wrapped", v, 16'h0007);
    rd(capture_pkg::ADDR_STATUS); chk("overflow", v, 16'h0001);
    cnt = 0;
    run(30, 0, 1'b0);
    wr(capture_pkg::ADDR_START, 16'h0001);
    rd(capture_pkg::ADDR_DATA); chk("after wrap", v, cnt[15:0]);
    rd(capture_pkg::ADDR_STATUS); chk("no overflow", v, 16'h0000);
    wr(capture_pkg::ADDR_STOP, 16'h0001);
    ticks <= 4'hF;
    wr(capture_pkg::ADDR_INSEL, 16'h0000);
    wr(capture_pkg::ADDR_MODE, mw(1'b0, 2'h1, 3'h1, 2'h0));
    wr(capture_pkg::ADDR_START, 16'h0001);
    for (k = 0; k < 4; k++) begin
      wr(capture_pkg::ADDR_MODE, mw(1'b1, k[1:0], 3'h1, 2'h2));
      if (k < 3) begin
        wait_irq;
        wait_irq;
        rd(capture_pkg::ADDR_DATA); chk("pin interval", v, k == 2 ? 16'h000A : 16'h0015);
      end
    end
    repeat (4) @(posedge clk);
    irq_cnt = 0;
    repeat (60) @(posedge clk);
    chk("prohibited edge", irq_cnt[15:0], 16'h0000);
    rd(capture_pkg::ADDR_MODE); chk("mode locked", v, mw(1'b0, 2'h3, 3'h1, 2'h0));
    for (k = 1; k < 3; k++) begin
      wr(capture_pkg::ADDR_STOP, 16'h0001);
      wr(capture_pkg::ADDR_INSEL, k[15:0]);
      wr(capture_pkg::ADDR_MODE, mw(1'b0, 2'h1, 3'h1, 2'h0));
      wr(capture_pkg::ADDR_START, 16'h0001);
      wait_irq;
      wait_irq;
      rd(capture_pkg::ADDR_DATA); chk("input interval", v, k == 1 ? 16'h0015 : 16'h000D);
    end
    summarize;
  end
endmodule : pulse_interval_capture_channel_tb_top
`default_nettype wire
